//--- src/edl_regs.vh
// Constants of the descriptor header loader: register map, fields, codes.
// Assumes byte addressing on an APB bus with 32-bit data, one word per register.
//
// Contract
// - Signature stored low byte, then high byte
// - Wrong signature: skip header, keep defaults
// - Block is four-byte prefix plus content
// - Prefix: type, length low, length high, checksum
// - Checksum is carry-free byte sum of content
// - Content length runs from 1 to 65535
// - Next prefix follows content without gap
// - Zero type byte ends the header
// - Bad checksum block dropped, walk goes on
// - Block position found by summing 4 plus lengths
// - Defaults give one bulk OUT endpoint, 64 bytes
// - Endpoint descriptor: seven bytes, type 5, address 0x01
// - Attributes bulk in bits 1:0, interval zero
// - String zero: four bytes, type 3, language 0x0409
// - Strings 1 to 3: maker, product, serial
// - Characters two bytes, code then zero
// - Serial string: 34 bytes, sixteen hex digits
// - Type III device 0, else type II device 4
// - Valid descriptor block replaces the default one; code only records length and pointer, DDATA keeps defaults
// - Valid firmware block only records its pointer
`ifndef EDL_REGS_VH
`define EDL_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define EDL_OFF_CTRL 8'h00
`define EDL_OFF_STATUS 8'h04
`define EDL_OFF_FW 8'h08
`define EDL_OFF_DEV 8'h0c
`define EDL_OFF_CFG 8'h10
`define EDL_OFF_STR 8'h14
`define EDL_OFF_SER_LO 8'h18
`define EDL_OFF_SER_HI 8'h1c
`define EDL_OFF_DSEL 8'h20
`define EDL_OFF_DDATA 8'h24

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define EDL_CTRL_RESTART 0
`define EDL_ST_DONE 0
`define EDL_ST_SIG_OK 1
`define EDL_ST_TYPE3 2
`define EDL_ST_BUSY 3
`define EDL_ST_BAD 4
`define EDL_ST_FW_V 24
`define EDL_ST_DEV_V 25
`define EDL_ST_CFG_V 26
`define EDL_ST_STR_V 27
`define EDL_SER_RST 32'h0000_0000
`define EDL_DSEL_RST 32'h0000_0000

// ****************************************************************
// Header codes and storage access
// ****************************************************************
`define EDL_PFX_BYTES 2'h3
`define EDL_TYPE_END 8'h00
`define EDL_TYPE_DEV 8'h03
`define EDL_TYPE_CFG 8'h04
`define EDL_TYPE_STR 8'h05
`define EDL_DEV_TRY0 3'h0
`define EDL_DEV_TRY1 3'h4

// ****************************************************************
// Default descriptor selectors and fixed bytes
// ****************************************************************
`define EDL_SEL_EP 3'h0
`define EDL_SEL_STR0 3'h1
`define EDL_SEL_STR1 3'h2
`define EDL_SEL_STR2 3'h3
`define EDL_SEL_STR3 3'h4
`define EDL_EP_LEN 8'h07
`define EDL_EP_TYPE 8'h05
`define EDL_EP_ADDR 8'h01
`define EDL_EP_ATTR 8'h02
`define EDL_EP_MPS 8'h40
`define EDL_STR_TYPE 8'h03
`define EDL_STR0_LEN 8'h04
`define EDL_LANG_LO 8'h09
`define EDL_LANG_HI 8'h04
`define EDL_STR1_LEN 8'h24
`define EDL_STR2_LEN 8'h2a
`define EDL_STR3_LEN 8'h22

`endif

//--- src/edl_cksum.v
// Carry-free byte sum over a block's content.
// Assumes clear and add never come in the same cycle from the walker.
`timescale 1ns/100ps
module edl_cksum (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Control
  input wire clr,
  input wire add,
  input wire [7:0] data,
  // Result
  output reg [7:0] sum_q
);

  // Sum wraps at eight bits, carries dropped
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      sum_q <= 8'h00;
    end else if (clr) begin
      sum_q <= 8'h00;
    end else if (add) begin
      sum_q <= sum_q + data;
    end
  end

endmodule // edl_cksum

//--- src/edl_desc_rom.v
// Default endpoint and string descriptor contents, one byte per lookup.
// Assumes the caller registers the byte; pure combinational lookup.
`timescale 1ns/100ps
`include "edl_regs.vh"
module edl_desc_rom (
  // Lookup
  input wire [2:0] sel,
  input wire [6:0] offs,
  input wire [63:0] serial,
  // Answer
  output reg [7:0] byte_o,
  output reg [7:0] len_o
);

  // Neutral text; any content of this length would do
  localparam [135:0] MAKER_TXT = "Example Maker Inc";
  localparam [159:0] PROD_TXT = "Serial Bridge Loader";

  // Hex digit as an ASCII code
  function [7:0] hex_char;
    input [3:0] nib;
    begin
      hex_char = (nib < 4'ha) ? {4'h3, nib} : (8'h37 + {4'h0, nib});
    end
  endfunction

  wire [5:0] ch = offs[6:1] - 6'h01;

  // Byte lookup per descriptor
  always @* begin
    byte_o = 8'h00;
    len_o = 8'h00;
    case (sel)
      `EDL_SEL_EP: begin
        len_o = `EDL_EP_LEN;
        case (offs)
          7'h00: byte_o = `EDL_EP_LEN;
          7'h01: byte_o = `EDL_EP_TYPE;
          7'h02: byte_o = `EDL_EP_ADDR;
          7'h03: byte_o = `EDL_EP_ATTR;
          7'h04: byte_o = `EDL_EP_MPS;
          default: byte_o = 8'h00;
        endcase
      end
      `EDL_SEL_STR0: begin
        len_o = `EDL_STR0_LEN;
        case (offs)
          7'h00: byte_o = `EDL_STR0_LEN;
          7'h01: byte_o = `EDL_STR_TYPE;
          7'h02: byte_o = `EDL_LANG_LO;
          7'h03: byte_o = `EDL_LANG_HI;
          default: byte_o = 8'h00;
        endcase
      end
      `EDL_SEL_STR1, `EDL_SEL_STR2, `EDL_SEL_STR3: begin
        if (sel == `EDL_SEL_STR1) begin
          len_o = `EDL_STR1_LEN;
        end else if (sel == `EDL_SEL_STR2) begin
          len_o = `EDL_STR2_LEN;
        end else begin
          len_o = `EDL_STR3_LEN;
        end
        if (offs == 7'h00) begin
          byte_o = len_o;
        end else if (offs == 7'h01) begin
          byte_o = `EDL_STR_TYPE;
        end else if ({1'b0, offs} < len_o && !offs[0]) begin
          // Even bytes carry the code, odd bytes stay zero
          if (sel == `EDL_SEL_STR1) begin
            byte_o = MAKER_TXT[(16 - ch) * 8 +: 8];
          end else if (sel == `EDL_SEL_STR2) begin
            byte_o = PROD_TXT[(19 - ch) * 8 +: 8];
          end else begin
            byte_o = hex_char(serial[(63 - 4 * ch) -: 4]);
          end
        end
      end
      default: begin
        byte_o = 8'h00;
        len_o = 8'h00;
      end
    endcase
  end

endmodule // edl_desc_rom

//--- src/edl_loader.v
// Boot header loader: signature check, descriptor block walk, APB registers.
// Assumes a two-wire controller on sys_clk that answers each byte read with
// a one-cycle ack or err pulse while the request is held.
`timescale 1ns/100ps
`include "edl_regs.vh"
module edl_loader #(
  // Value is arbitrary; set to the product number of the part
  parameter [15:0] PRODUCT_NUM = 16'h5a6b,
  // Block type that carries binary firmware
  parameter [7:0] FW_TYPE = 8'h06,
  // Autoexec firmware block type
  parameter [7:0] FW_AUTO_TYPE = 8'h07
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // Storage byte reads through the two-wire controller
  output reg eep_req_q,
  output reg [15:0] eep_addr_q,
  output reg [2:0] eep_dev_q,
  output reg eep_type3_q,
  input wire eep_ack,
  input wire eep_err,
  input wire [7:0] eep_data,
  // Boot sequence
  output reg done_q,
  output reg sig_ok_q
);

  // ****************************************************************
  // Walker states
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SIG = 3'h1;
  localparam [2:0] S_PFX = 3'h2;
  localparam [2:0] S_CONT = 3'h3;
  localparam [2:0] S_VERD = 3'h4;
  localparam [2:0] S_DONE = 3'h5;

  reg [2:0] state_q;
  reg [1:0] idx_q;
  reg try_q;
  reg [7:0] sig_lo_q;
  reg [7:0] type_q;
  reg [15:0] len_q;
  reg [7:0] ck_q;
  reg [15:0] cnt_q;
  reg [15:0] cont_ptr_q;
  reg [7:0] blocks_q;
  reg [7:0] bad_q;
  reg malformed_q;
  reg boot_q;
  reg [15:0] fw_ptr_q;
  reg fw_v_q;
  reg [31:0] dev_q;
  reg dev_v_q;
  reg [31:0] cfg_q;
  reg cfg_v_q;
  reg [31:0] str_q;
  reg str_v_q;
  reg [31:0] ser_lo_q;
  reg [31:0] ser_hi_q;
  reg [31:0] dsel_q;
  reg restart_q;
  wire [7:0] sum;
  wire [7:0] rom_byte;
  wire [7:0] rom_len;

  // One byte answered by the controller
  wire got = eep_req_q & eep_ack;
  wire fail = eep_req_q & eep_err;
  wire fetching = (state_q == S_SIG) || (state_q == S_PFX) || (state_q == S_CONT);

  // ****************************************************************
  // Submodules
  // ****************************************************************
  // Content sum, cleared while the prefix is read
  edl_cksum u_cksum (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clr(state_q == S_PFX),
    .add((state_q == S_CONT) & got),
    .data(eep_data),
    .sum_q(sum)
  );

  // Default descriptors; serial registers, low byte of the first register in the top byte
  edl_desc_rom u_rom (
    .sel(dsel_q[2:0]),
    .offs(dsel_q[14:8]),
    .serial({ser_lo_q[7:0], ser_lo_q[15:8], ser_lo_q[23:16], ser_lo_q[31:24],
             ser_hi_q[7:0], ser_hi_q[15:8], ser_hi_q[23:16], ser_hi_q[31:24]}),
    .byte_o(rom_byte),
    .len_o(rom_len)
  );

  // ****************************************************************
  // Header walker
  // ****************************************************************
  // Sequential byte reads, one outstanding request at a time
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      idx_q <= 2'h0;
      try_q <= 1'b0;
      sig_lo_q <= 8'h00;
      type_q <= 8'h00;
      len_q <= 16'h0000;
      ck_q <= 8'h00;
      cnt_q <= 16'h0000;
      cont_ptr_q <= 16'h0000;
      blocks_q <= 8'h00;
      bad_q <= 8'h00;
      malformed_q <= 1'b0;
      boot_q <= 1'b1;
      fw_ptr_q <= 16'h0000;
      fw_v_q <= 1'b0;
      dev_q <= 32'h0000_0000;
      dev_v_q <= 1'b0;
      cfg_q <= 32'h0000_0000;
      cfg_v_q <= 1'b0;
      str_q <= 32'h0000_0000;
      str_v_q <= 1'b0;
      eep_req_q <= 1'b0;
      eep_addr_q <= 16'h0000;
      eep_dev_q <= `EDL_DEV_TRY0;
      eep_type3_q <= 1'b1;
      done_q <= 1'b0;
      sig_ok_q <= 1'b0;
    end else begin
      boot_q <= 1'b0;
      // Request stands until answered, then drops until the next cycle spent fetching
      if (got || fail) begin
        eep_req_q <= 1'b0;
        eep_addr_q <= eep_addr_q + 16'h0001;
      end else if (fetching && !eep_req_q) begin
        eep_req_q <= 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (boot_q || restart_q) begin
            // Start over with first addressing scheme, defaults in force
            state_q <= S_SIG;
            idx_q <= 2'h0;
            try_q <= 1'b0;
            eep_addr_q <= 16'h0000;
            eep_dev_q <= `EDL_DEV_TRY0;
            eep_type3_q <= 1'b1;
            blocks_q <= 8'h00;
            bad_q <= 8'h00;
            malformed_q <= 1'b0;
            fw_v_q <= 1'b0;
            dev_v_q <= 1'b0;
            cfg_v_q <= 1'b0;
            str_v_q <= 1'b0;
            done_q <= 1'b0;
            sig_ok_q <= 1'b0;
          end
        end
        S_SIG: begin
          if (got && idx_q == 2'h0) begin
            sig_lo_q <= eep_data;
            idx_q <= 2'h1;
          end else if ((got && {eep_data, sig_lo_q} != PRODUCT_NUM) || fail) begin
            if (!try_q) begin
              // Second attempt with the other addressing scheme
              try_q <= 1'b1;
              idx_q <= 2'h0;
              eep_addr_q <= 16'h0000;
              eep_dev_q <= `EDL_DEV_TRY1;
              eep_type3_q <= 1'b0;
            end else begin
              state_q <= S_DONE;
            end
          end else if (got) begin
            sig_ok_q <= 1'b1;
            idx_q <= 2'h0;
            state_q <= S_PFX;
          end
        end
        S_PFX: begin
          if (fail) begin
            malformed_q <= 1'b1;
            state_q <= S_DONE;
          end else if (got) begin
            case (idx_q)
              2'h0: begin
                type_q <= eep_data;
                if (eep_data == `EDL_TYPE_END) begin
                  state_q <= S_DONE;
                end
              end
              2'h1: len_q[7:0] <= eep_data;
              2'h2: len_q[15:8] <= eep_data;
              default: ck_q <= eep_data;
            endcase
            idx_q <= idx_q + 2'h1;
            if (idx_q == `EDL_PFX_BYTES) begin
              if (len_q == 16'h0000) begin
                malformed_q <= 1'b1;
                state_q <= S_DONE;
              end else begin
                cnt_q <= len_q;
                cont_ptr_q <= eep_addr_q + 16'h0001;
                state_q <= S_CONT;
              end
            end
          end
        end
        S_CONT: begin
          if (fail) begin
            malformed_q <= 1'b1;
            state_q <= S_DONE;
          end else if (got) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              state_q <= S_VERD;
            end
          end
        end
        S_VERD: begin
          // Address already points at the next prefix
          blocks_q <= blocks_q + 8'h01;
          idx_q <= 2'h0;
          state_q <= S_PFX;
          if (sum != ck_q) begin
            bad_q <= bad_q + 8'h01;
          end else if (type_q == `EDL_TYPE_DEV) begin
            dev_q <= {len_q, cont_ptr_q};
            dev_v_q <= 1'b1;
          end else if (type_q == `EDL_TYPE_CFG) begin
            cfg_q <= {len_q, cont_ptr_q};
            cfg_v_q <= 1'b1;
          end else if (type_q == `EDL_TYPE_STR) begin
            str_q <= {len_q, cont_ptr_q};
            str_v_q <= 1'b1;
          end else if (type_q == FW_TYPE || type_q == FW_AUTO_TYPE) begin
            fw_ptr_q <= cont_ptr_q;
            fw_v_q <= 1'b1;
          end
        end
        S_DONE: begin
          done_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state; write takes effect at the edge where pready is seen
  wire acc = psel & penable;
  wire wr_now = acc & pready_q & pwrite;

  // Read mux, zero for unmapped offsets
  reg [31:0] rd_mux;
  reg hit;
  always @* begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `EDL_OFF_CTRL: rd_mux = 32'h0000_0000;
      `EDL_OFF_STATUS: begin
        rd_mux[`EDL_ST_DONE] = done_q;
        rd_mux[`EDL_ST_SIG_OK] = sig_ok_q;
        rd_mux[`EDL_ST_TYPE3] = eep_type3_q;
        rd_mux[`EDL_ST_BUSY] = (state_q != S_IDLE);
        rd_mux[`EDL_ST_BAD] = malformed_q;
        rd_mux[15:8] = blocks_q;
        rd_mux[23:16] = bad_q;
        rd_mux[`EDL_ST_FW_V] = fw_v_q;
        rd_mux[`EDL_ST_DEV_V] = dev_v_q;
        rd_mux[`EDL_ST_CFG_V] = cfg_v_q;
        rd_mux[`EDL_ST_STR_V] = str_v_q;
      end
      `EDL_OFF_FW: rd_mux = {16'h0000, fw_ptr_q};
      `EDL_OFF_DEV: rd_mux = dev_q;
      `EDL_OFF_CFG: rd_mux = cfg_q;
      `EDL_OFF_STR: rd_mux = str_q;
      `EDL_OFF_SER_LO: rd_mux = ser_lo_q;
      `EDL_OFF_SER_HI: rd_mux = ser_hi_q;
      `EDL_OFF_DSEL: rd_mux = {17'h00000, dsel_q[14:8], 5'h00, dsel_q[2:0]};
      `EDL_OFF_DDATA: rd_mux = {16'h0000, rom_len, rom_byte};
      default: hit = 1'b0;
    endcase
  end

  // Handshake, read data and writable registers
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      ser_lo_q <= `EDL_SER_RST;
      ser_hi_q <= `EDL_SER_RST;
      dsel_q <= `EDL_DSEL_RST;
      restart_q <= 1'b0;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~hit;
      prdata_q <= (acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
      // Restart request held until the walker is idle
      if (state_q == S_IDLE) begin
        restart_q <= 1'b0;
      end
      if (wr_now) begin
        case (paddr)
          `EDL_OFF_CTRL: begin
            if (pwdata[`EDL_CTRL_RESTART]) begin
              restart_q <= 1'b1;
            end
          end
          `EDL_OFF_SER_LO: ser_lo_q <= pwdata;
          `EDL_OFF_SER_HI: ser_hi_q <= pwdata;
          `EDL_OFF_DSEL: dsel_q <= {17'h00000, pwdata[14:8], 5'h00, pwdata[2:0]};
          default: ;
        endcase
      end
    end
  end

endmodule // edl_loader

//--- tb/edl_loader_props.sv
// Checker for the loader's APB port and storage read port.
// Assumes it is bound onto every instance of edl_loader.
`timescale 1ns/100ps
module edl_loader_props (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input logic [31:0] prdata_q,
  input logic pready_q,
  input logic pslverr_q,
  // Storage reads
  input logic eep_req_q,
  input logic [15:0] eep_addr_q,
  input logic [2:0] eep_dev_q,
  input logic eep_type3_q,
  input wire eep_ack,
  input wire eep_err,
  input wire [7:0] eep_data,
  // Boot sequence
  input logic done_q,
  input logic sig_ok_q
);
  // ****************
  // Sequences and properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Byte taken, request dropped, then raised again
  sequence s_got_byte;
    eep_req_q && eep_ack ##1 !eep_req_q ##1 eep_req_q;
  endsequence
  // Type III read refused while fetching the signature
  sequence s_sig_refused;
    eep_req_q && eep_err && eep_type3_q && eep_addr_q < 16'h2;
  endsequence
  property p_rdy_wait;
    psel && penable && !pready_q |=> pready_q;
  endproperty
  property p_rdy_one;
    pready_q |=> !pready_q;
  endproperty
  property p_err_zero;
    pslverr_q |-> pready_q && prdata_q == 32'h0;
  endproperty
  property p_req_hold;
    eep_req_q && !eep_ack && !eep_err |=> eep_req_q && $stable(eep_addr_q)
      && $stable(eep_dev_q) && $stable(eep_type3_q);
  endproperty
  property p_req_drop;
    eep_req_q && (eep_ack || eep_err) |=> !eep_req_q;
  endproperty
  property p_seq;
    s_got_byte |-> eep_addr_q == $past(eep_addr_q, 2) + 16'h1
      || (eep_addr_q == 16'h0 && !eep_type3_q);
  endproperty
  property p_retry;
    s_sig_refused |-> ##[2:4] (eep_req_q && !eep_type3_q && eep_dev_q == 3'h4
      && eep_addr_q == 16'h0);
  endproperty
  property p_start;
    $rose(rst_b) |-> ##[1:3] (eep_req_q && eep_addr_q == 16'h0 && eep_type3_q
      && eep_dev_q == 3'h0);
  endproperty
  property p_done_idle;
    done_q |-> !eep_req_q;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  a_req_hold: assert property (p_req_hold) else $error("request moved");
  a_req_drop: assert property (p_req_drop) else $error("request not dropped");
  a_seq: assert property (p_seq) else $error("address not sequential");
  a_retry: assert property (p_retry) else $error("no second try");
  a_start: assert property (p_start) else $error("no first read");
  a_done_idle: assert property (p_done_idle) else $error("read after done");
endmodule // edl_loader_props

bind edl_loader edl_loader_props edl_loader_props_inst (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
  .pready_q(pready_q), .pslverr_q(pslverr_q), .eep_req_q(eep_req_q),
  .eep_addr_q(eep_addr_q), .eep_dev_q(eep_dev_q), .eep_type3_q(eep_type3_q),
  .eep_ack(eep_ack), .eep_err(eep_err), .eep_data(eep_data),
  .done_q(done_q), .sig_ok_q(sig_ok_q)
);

//--- tb/edl_eeprom_model.sv
// Storage model: byte array behind the two-wire controller's read port.
// Assumes one request at a time, held until ack or err.
`timescale 1ns/100ps
module edl_eeprom_model (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Byte read request
  input wire eep_req_q,
  input wire [15:0] eep_addr_q,
  input wire [2:0] eep_dev_q,
  input wire eep_type3_q,
  // Behaviour knobs
  input wire slow,
  input wire t3_fail,
  // Answer
  output reg eep_ack,
  output reg eep_err,
  output reg [7:0] eep_data
);
  // ****************
  // Storage and answer
  // ****************
  reg [7:0] mem [0:255];
  reg [3:0] wait_q;
  reg served_q;
  // One answer per request; data line toggles when not valid
  always @(posedge sys_clk) begin
    eep_ack <= 1'b0;
    eep_err <= 1'b0;
    eep_data <= ~eep_data;
    if (!rst_b) begin
      wait_q <= 4'h0;
      served_q <= 1'b0;
      eep_data <= 8'ha5;
    end else if (!eep_req_q) begin
      wait_q <= 4'h0;
      served_q <= 1'b0;
    end else if (!served_q && wait_q < (slow ? 4'h6 : 4'h1)) begin
      wait_q <= wait_q + 4'h1;
    end else if (!served_q) begin
      served_q <= 1'b1;
      if (eep_type3_q ? (t3_fail || eep_dev_q != 3'h0) : eep_dev_q != 3'h4) begin
        eep_err <= 1'b1;
      end else begin
        eep_ack <= 1'b1;
        eep_data <= mem[eep_addr_q[7:0]];
      end
    end
  end
endmodule // edl_eeprom_model

//--- tb/edl_loader_tb.sv
// Bench for the descriptor header loader: defaults, walks, retries.
// Assumes the storage model answers the loader's byte reads.
`timescale 1ns/100ps
`include "edl_regs.vh"
module edl_loader_tb;
  // ****************
  // Signals and instances
  // ****************
  localparam [15:0] PNUM = 16'h5a6b; // Value is arbitrary
  logic sys_clk, rst_b, psel, penable, pwrite, slow, t3_fail, e;
  logic pready_q, pslverr_q, eep_req_q, eep_type3_q, eep_ack, eep_err;
  logic done_q, sig_ok_q;
  logic [7:0] paddr, eep_data, b;
  logic [31:0] pwdata, prdata_q, st;
  logic [15:0] eep_addr_q;
  logic [2:0] eep_dev_q;
  logic [63:0] ser;
  int mismatches, cmp_count, cyc, p;
  logic [7:0] epb [0:6] = '{8'h07, 8'h05, 8'h01, 8'h02, 8'h40, 8'h00, 8'h00};
  logic [7:0] s0b [0:3] = '{8'h04, 8'h03, 8'h09, 8'h04};
  edl_loader #(.PRODUCT_NUM(PNUM)) edl_loader_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .eep_req_q(eep_req_q), .eep_addr_q(eep_addr_q), .eep_dev_q(eep_dev_q),
    .eep_type3_q(eep_type3_q), .eep_ack(eep_ack), .eep_err(eep_err),
    .eep_data(eep_data), .done_q(done_q), .sig_ok_q(sig_ok_q));
  edl_eeprom_model edl_eeprom_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .eep_req_q(eep_req_q), .eep_addr_q(eep_addr_q), .eep_dev_q(eep_dev_q),
    .eep_type3_q(eep_type3_q), .slow(slow), .t3_fail(t3_fail),
    .eep_ack(eep_ack), .eep_err(eep_err), .eep_data(eep_data));
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      results();
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready_q !== 1'b1);
    st = prdata_q;
    e = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dchk(input logic [2:0] s, input logic [6:0] o, input logic [7:0] x,
    input logic [7:0] n);
    apb(1'b1, `EDL_OFF_DSEL, {17'h0, o, 5'h0, s});
    apb(1'b0, `EDL_OFF_DDATA, 32'h0);
    chk("ddata", {16'h0, n, x}, st);
  endtask
  task automatic put(input int a, input logic [7:0] v);
    edl_eeprom_model_inst.mem[a] = v;
  endtask
  // Block prefix, content and carry-free sum, good or spoilt
  task automatic blk(input logic [7:0] t, input logic [15:0] n, input logic ok);
    b = 8'h00;
    for (int k = 0; k < n; k++) begin
      put(p + 4 + k, 8'(p + k));
      b += 8'(p + k);
    end
    put(p, t);
    put(p + 1, n[7:0]);
    put(p + 2, n[15:8]);
    put(p + 3, ok ? b : ~b);
    p = p + 4 + n;
  endtask
  task automatic walk();
    apb(1'b1, `EDL_OFF_CTRL, 32'h1);
    while (done_q !== 1'b0) @(posedge sys_clk);
    while (done_q !== 1'b1) @(posedge sys_clk);
    apb(1'b0, `EDL_OFF_STATUS, 32'h0);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    {rst_b, psel, penable, pwrite, slow, t3_fail} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    p = 2;
    for (int i = 0; i < 256; i++) put(i, 8'hff);
    put(0, PNUM[7:0]);
    put(1, PNUM[15:8]);
    blk(8'h03, 16'd2, 1'b1);
    blk(8'h04, 16'd1, 1'b0);
    blk(8'h06, 16'd3, 1'b1);
    blk(8'h05, 16'd1, 1'b1);
    put(p, 8'h00);
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    apb(1'b0, `EDL_OFF_SER_LO, 32'h0);
    chk("ser_lo reset", `EDL_SER_RST, st);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, st);
    apb(1'b1, `EDL_OFF_SER_LO, 32'h1032_5476);
    apb(1'b1, `EDL_OFF_SER_HI, 32'h98ba_dcfe);
    apb(1'b0, `EDL_OFF_SER_HI, 32'h0);
    chk("ser_hi", 32'h98ba_dcfe, st);
    for (int i = 0; i < 7; i++) dchk(`EDL_SEL_EP, 7'(i), epb[i], 8'h07);
    for (int i = 0; i < 4; i++) dchk(`EDL_SEL_STR0, 7'(i), s0b[i], 8'h04);
    dchk(`EDL_SEL_STR1, 7'h1, 8'h03, 8'h24);
    dchk(`EDL_SEL_STR1, 7'h3, 8'h00, 8'h24);
    dchk(`EDL_SEL_STR1, 7'h2, 8'h45, 8'h24);
    dchk(`EDL_SEL_STR2, 7'h2, 8'h53, 8'h2a);
    dchk(`EDL_SEL_STR2, 7'h0, 8'h2a, 8'h2a);
    dchk(`EDL_SEL_STR3, 7'h1, 8'h03, 8'h22);
    ser = {32'h98ba_dcfe, 32'h1032_5476};
    for (int k = 0; k < 16; k++) begin
      b = ser[8 * (k / 2) +: 8];
      b = k[0] ? {4'h0, b[3:0]} : {4'h0, b[7:4]};
      dchk(`EDL_SEL_STR3, 7'(2 + 2 * k), b < 8'ha ? 8'h30 + b : 8'h37 + b, 8'h22);
      dchk(`EDL_SEL_STR3, 7'(3 + 2 * k), 8'h00, 8'h22);
    end
    $display("test defaults done");
    while (done_q !== 1'b1) @(posedge sys_clk);
    apb(1'b1, `EDL_OFF_STATUS, 32'h0);
    apb(1'b0, `EDL_OFF_STATUS, 32'h0);
    chk("status", 32'h0b01_0407, st);
    chk("sig_ok", 32'h1, {31'h0, sig_ok_q});
    apb(1'b0, `EDL_OFF_FW, 32'h0);
    chk("fw ptr", 32'h0000_0011, st);
    apb(1'b0, `EDL_OFF_DEV, 32'h0);
    chk("dev", 32'h0002_0006, st);
    apb(1'b0, `EDL_OFF_STR, 32'h0);
    chk("str", 32'h0001_0018, st);
    $display("test walk done");
    slow <= 1'b1;
    t3_fail <= 1'b1;
    put(11, 8'h08);
    put(13, 8'h07);
    walk();
    chk("status second try", 32'h0f00_0403, st);
    apb(1'b0, `EDL_OFF_CFG, 32'h0);
    chk("cfg", 32'h0001_000c, st);
    apb(1'b0, `EDL_OFF_FW, 32'h0);
    chk("autoexec fw ptr", 32'h0000_0011, st);
    $display("test retry done");
    slow <= 1'b0;
    t3_fail <= 1'b0;
    put(0, PNUM[15:8]);
    put(1, PNUM[7:0]);
    walk();
    chk("bad sig status", 32'h1, st & 32'h3);
    chk("bad sig port", 32'h0, {31'h0, sig_ok_q});
    $display("test signature done");
    put(0, PNUM[7:0]);
    put(1, PNUM[15:8]);
    put(3, 8'h00);
    walk();
    chk("zero length", 32'h13, st & 32'h13);
    $display("test zero length done");
    results();
  end
endmodule // edl_loader_tb
